/* File: sio_pkg.sv */
package sio_pkg;
    // Host I/O map of the configuration port pair
    localparam logic [15:0] SIO_INDEX_PORT     = 16'h002e;
    localparam logic [15:0] SIO_DATA_PORT      = 16'h002f;
    localparam logic [7:0]  SIO_KEY_UNLOCK     = 8'h87;
    localparam logic [7:0]  SIO_KEY_LOCK       = 8'haa;
    localparam logic [7:0]  SIO_UNMAPPED_READ  = 8'hff;
    localparam logic [7:0]  SIO_IDLE_READ      = 8'h00;

    // Configuration register indices
    localparam logic [7:0]  SIO_IDX_LDN        = 8'h07;
    localparam logic [7:0]  SIO_IDX_ENABLE     = 8'h30;
    localparam logic [7:0]  SIO_IDX_DIR        = 8'he0;
    localparam logic [7:0]  SIO_IDX_VALUE      = 8'he1;
    localparam logic [7:0]  SIO_IDX_POLARITY   = 8'he2;

    // Logical devices
    localparam logic [7:0]  SIO_LDN_GPIO       = 8'h07;
    localparam logic [7:0]  SIO_LDN_ENABLE     = 8'h09;

    localparam int          SIO_GPIO_W         = 8;
    localparam int          SIO_ENABLE_BIT     = 7;
    localparam logic [7:0]  SIO_ENABLE_MASK    = 8'h80;

    // Reset values
    localparam logic [7:0]  SIO_RST_INDEX      = 8'h00;
    localparam logic [7:0]  SIO_RST_LDN        = 8'h00;
    localparam logic [7:0]  SIO_RST_ENABLE     = 8'h00;
    localparam logic [7:0]  SIO_RST_DIR        = 8'hff;
    localparam logic [7:0]  SIO_RST_VALUE      = 8'h00;
    localparam logic [7:0]  SIO_RST_POLARITY   = 8'h00;

    // Host controller command registers
    localparam logic [3:0]  SIO_HREG_CTRL      = 4'h0;
    localparam logic [3:0]  SIO_HREG_LDN       = 4'h1;
    localparam logic [3:0]  SIO_HREG_INDEX     = 4'h2;
    localparam logic [3:0]  SIO_HREG_WDATA     = 4'h3;
    localparam logic [3:0]  SIO_HREG_STATUS    = 4'h4;
    localparam logic [3:0]  SIO_HREG_RDATA     = 4'h5;
    localparam int          SIO_CTRL_START_BIT = 0;
    localparam int          SIO_CTRL_OP_LO     = 1;

    typedef enum logic [1:0] {
        SIO_OP_WRITE  = 2'h0,
        SIO_OP_READ   = 2'h1,
        SIO_OP_ENABLE = 2'h2
    } sio_op_t;
endpackage : sio_pkg

/* File: sio_io_if.sv */
`timescale 1ns/1ps
interface sio_io_if;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_rdata;

    modport dev  (input io_addr, input io_wdata, input io_wr, input io_rd, output io_rdata);
    modport host (output io_addr, output io_wdata, output io_wr, output io_rd, input io_rdata);
endinterface : sio_io_if

/* File: sio_pin_sync.sv */
`timescale 1ns/1ps
module sio_pin_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pin,
    output logic      level
);
    logic s1_reg, s2_reg, s3_reg, level_reg;
    logic level_next;

    // Only the second and third stage are compared; the first feeds the second alone
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg    <= pin;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule : sio_pin_sync

/* File: sio_gpio_dev.sv */
`timescale 1ns/1ps
module sio_gpio_dev
    import sio_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    sio_io_if.dev                      bus,
    input  wire logic [SIO_GPIO_W-1:0] gpio_in,
    output logic      [SIO_GPIO_W-1:0] gpio_out,
    output logic      [SIO_GPIO_W-1:0] gpio_oe,
    output logic                       config_mode
);
    logic                  key_seen_reg;
    logic                  key_seen_next;
    logic                  cfg_reg;
    logic                  cfg_next;
    logic [7:0]            index_reg;
    logic [7:0]            index_next;
    logic [7:0]            ldn_reg;
    logic [7:0]            ldn_next;
    logic [7:0]            enable_reg;
    logic [7:0]            enable_next;
    logic [SIO_GPIO_W-1:0] dir_reg;
    logic [SIO_GPIO_W-1:0] dir_next;
    logic [SIO_GPIO_W-1:0] value_reg;
    logic [SIO_GPIO_W-1:0] value_next;
    logic [SIO_GPIO_W-1:0] pol_reg;
    logic [SIO_GPIO_W-1:0] pol_next;
    logic [7:0]            rdata_reg;
    logic [7:0]            rdata_next;
    logic [SIO_GPIO_W-1:0] pin_level;
    logic [SIO_GPIO_W-1:0] pin_view;
    logic [SIO_GPIO_W-1:0] out_reg;
    logic [SIO_GPIO_W-1:0] out_next;
    logic [SIO_GPIO_W-1:0] oe_reg;
    logic [SIO_GPIO_W-1:0] oe_next;
    logic                  hit_index;
    logic                  hit_data;
    logic                  gpio_on;

    // Decodes whether the current index names a register of a given logical device
    function automatic logic sel(input logic [7:0] ldn, input logic [7:0] idx,
                                 input logic [7:0] want_ldn, input logic [7:0] want_idx);
        sel = (ldn == want_ldn) && (idx == want_idx);
    endfunction : sel

    genvar gi;
    generate
        for (gi = 0; gi < SIO_GPIO_W; gi++) begin : g_sync
            sio_pin_sync u_sync (
                .clk    (clk),
                .resetn (resetn),
                .pin    (gpio_in[gi]),
                .level  (pin_level[gi])
            );
        end
    endgenerate

    assign hit_index = (bus.io_addr == SIO_INDEX_PORT);
    assign hit_data  = (bus.io_addr == SIO_DATA_PORT);
    assign gpio_on   = enable_reg[SIO_ENABLE_BIT];

    // Pin state as the host sees it, after polarity
    assign pin_view  = pin_level ^ pol_reg;

    // Configuration mode key sequence
    always_comb begin
        key_seen_next = key_seen_reg;
        cfg_next      = cfg_reg;
        if ((bus.io_wr || bus.io_rd) && (hit_index || hit_data)) begin
            key_seen_next = 1'b0;
            if (!cfg_reg && bus.io_wr && hit_index && bus.io_wdata == SIO_KEY_UNLOCK) begin
                if (key_seen_reg) begin
                    cfg_next = 1'b1;
                end else begin
                    key_seen_next = 1'b1;
                end
            end
            if (cfg_reg && bus.io_wr && hit_index && bus.io_wdata == SIO_KEY_LOCK) begin
                cfg_next = 1'b0;
            end
        end
    end

    // Configuration register writes
    always_comb begin
        index_next  = index_reg;
        ldn_next    = ldn_reg;
        enable_next = enable_reg;
        dir_next    = dir_reg;
        value_next  = value_reg;
        pol_next    = pol_reg;
        if (cfg_reg && bus.io_wr) begin
            if (hit_index && bus.io_wdata != SIO_KEY_LOCK) begin
                index_next = bus.io_wdata;
            end
            if (hit_data) begin
                if (index_reg == SIO_IDX_LDN) begin
                    ldn_next = bus.io_wdata;
                end
                if (sel(ldn_reg, index_reg, SIO_LDN_ENABLE, SIO_IDX_ENABLE)) begin
                    enable_next = bus.io_wdata;
                end
                if (sel(ldn_reg, index_reg, SIO_LDN_GPIO, SIO_IDX_DIR)) begin
                    dir_next = bus.io_wdata;
                end
                if (sel(ldn_reg, index_reg, SIO_LDN_GPIO, SIO_IDX_VALUE)) begin
                    // Input bits keep their stored value
                    value_next = (value_reg & dir_reg) | (bus.io_wdata & ~dir_reg);
                end
                if (sel(ldn_reg, index_reg, SIO_LDN_GPIO, SIO_IDX_POLARITY)) begin
                    pol_next = bus.io_wdata;
                end
            end
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_comb begin
        rdata_next = SIO_IDLE_READ;
        if (bus.io_rd) begin
            rdata_next = SIO_UNMAPPED_READ;
            if (cfg_reg && hit_index) begin
                rdata_next = index_reg;
            end
            if (cfg_reg && hit_data) begin
                if (index_reg == SIO_IDX_LDN) begin
                    rdata_next = ldn_reg;
                end else if (sel(ldn_reg, index_reg, SIO_LDN_ENABLE, SIO_IDX_ENABLE)) begin
                    rdata_next = enable_reg;
                end else if (sel(ldn_reg, index_reg, SIO_LDN_GPIO, SIO_IDX_DIR)) begin
                    rdata_next = dir_reg;
                end else if (sel(ldn_reg, index_reg, SIO_LDN_GPIO, SIO_IDX_VALUE)) begin
                    rdata_next = (pin_view & dir_reg) | (value_reg & ~dir_reg);
                end else if (sel(ldn_reg, index_reg, SIO_LDN_GPIO, SIO_IDX_POLARITY)) begin
                    rdata_next = pol_reg;
                end
            end
        end
    end

    // Pin drive: output pins only while GPIO is enabled
    always_comb begin
        out_next = value_reg ^ pol_reg;
        oe_next  = gpio_on ? ~dir_reg : '0;
    end

    // Key sequence state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            key_seen_reg <= 1'b0;
            cfg_reg      <= 1'b0;
        end else begin
            key_seen_reg <= key_seen_next;
            cfg_reg      <= cfg_next;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            index_reg  <= SIO_RST_INDEX;
            ldn_reg    <= SIO_RST_LDN;
            enable_reg <= SIO_RST_ENABLE;
            dir_reg    <= SIO_RST_DIR;
            value_reg  <= SIO_RST_VALUE;
            pol_reg    <= SIO_RST_POLARITY;
        end else begin
            index_reg  <= index_next;
            ldn_reg    <= ldn_next;
            enable_reg <= enable_next;
            dir_reg    <= dir_next;
            value_reg  <= value_next;
            pol_reg    <= pol_next;
        end
    end

    // Read answer, one cycle long
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_reg <= SIO_IDLE_READ;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Pin drive, released while GPIO is disabled
    always_ff @(posedge clk) begin
        if (!resetn) begin
            out_reg <= '0;
            oe_reg  <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end

    assign bus.io_rdata = rdata_reg;
    assign gpio_out     = out_reg;
    assign gpio_oe      = oe_reg;
    assign config_mode  = cfg_reg;
endmodule : sio_gpio_dev

/* File: sio_gpio_host.sv */
`timescale 1ns/1ps
module sio_gpio_host
    import sio_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    sio_io_if.host          bus,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata
);
    typedef enum logic [9:0] {
        SIO_S_IDLE    = 10'h001,
        SIO_S_KEY1    = 10'h002,
        SIO_S_KEY2    = 10'h004,
        SIO_S_LDN_IDX = 10'h008,
        SIO_S_LDN_DAT = 10'h010,
        SIO_S_REG_IDX = 10'h020,
        SIO_S_DATA_WR = 10'h040,
        SIO_S_DATA_RD = 10'h080,
        SIO_S_RD_WAIT = 10'h100,
        SIO_S_LOCK    = 10'h200
    } sio_state_t;

    sio_state_t  state_reg, state_next;
    sio_op_t     op_reg, op_next;
    logic [7:0]  ldn_reg, ldn_next, index_reg, index_next;
    logic [7:0]  wdata_reg, wdata_next, result_reg, result_next;
    logic [7:0]  hrdata_reg, hrdata_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0]  iow_reg, iow_next;
    logic        wr_reg, wr_next, rd_reg, rd_next;
    logic        start;

    assign start = reg_wr && (reg_addr == SIO_HREG_CTRL) && reg_wdata[SIO_CTRL_START_BIT]
                   && (state_reg == SIO_S_IDLE);

    always_comb begin
        state_next  = state_reg;
        op_next     = op_reg;
        ldn_next    = ldn_reg;
        index_next  = index_reg;
        wdata_next  = wdata_reg;
        result_next = result_reg;
        if (reg_wr && state_reg == SIO_S_IDLE) begin
            unique case (reg_addr)
                SIO_HREG_LDN:   ldn_next   = reg_wdata;
                SIO_HREG_INDEX: index_next = reg_wdata;
                SIO_HREG_WDATA: wdata_next = reg_wdata;
                default:        ;
            endcase
        end
        unique case (state_reg)
            SIO_S_IDLE: if (start) begin
                op_next    = sio_op_t'(reg_wdata[SIO_CTRL_OP_LO +: 2]);
                state_next = SIO_S_KEY1;
            end
            SIO_S_KEY1:    state_next = SIO_S_KEY2;
            SIO_S_KEY2:    state_next = SIO_S_LDN_IDX;
            SIO_S_LDN_IDX: state_next = SIO_S_LDN_DAT;
            SIO_S_LDN_DAT: state_next = SIO_S_REG_IDX;
            SIO_S_REG_IDX: state_next = (op_reg == SIO_OP_WRITE) ? SIO_S_DATA_WR : SIO_S_DATA_RD;
            SIO_S_DATA_RD: state_next = SIO_S_RD_WAIT;
            SIO_S_RD_WAIT: begin
                result_next = bus.io_rdata;
                state_next  = (op_reg == SIO_OP_ENABLE) ? SIO_S_DATA_WR : SIO_S_LOCK;
            end
            SIO_S_DATA_WR: state_next = SIO_S_LOCK;
            SIO_S_LOCK:    state_next = SIO_S_IDLE;
            default:       state_next = SIO_S_IDLE;
        endcase
    end

    // Bus cycle registered for the state being entered
    always_comb begin
        addr_next = SIO_INDEX_PORT;
        iow_next  = 8'h00;
        wr_next   = 1'b0;
        rd_next   = 1'b0;
        unique case (state_next)
            SIO_S_KEY1, SIO_S_KEY2: begin
                wr_next  = 1'b1;
                iow_next = SIO_KEY_UNLOCK;
            end
            SIO_S_LDN_IDX: begin
                wr_next  = 1'b1;
                iow_next = SIO_IDX_LDN;
            end
            SIO_S_LDN_DAT: begin
                wr_next   = 1'b1;
                addr_next = SIO_DATA_PORT;
                iow_next  = (op_reg == SIO_OP_ENABLE) ? SIO_LDN_ENABLE : ldn_reg;
            end
            SIO_S_REG_IDX: begin
                wr_next  = 1'b1;
                iow_next = (op_reg == SIO_OP_ENABLE) ? SIO_IDX_ENABLE : index_reg;
            end
            SIO_S_DATA_RD: begin
                rd_next   = 1'b1;
                addr_next = SIO_DATA_PORT;
            end
            SIO_S_DATA_WR: begin
                wr_next   = 1'b1;
                addr_next = SIO_DATA_PORT;
                // Read-modify-write keeps the other enable bits
                iow_next  = (op_reg == SIO_OP_ENABLE) ? (bus.io_rdata | SIO_ENABLE_MASK)
                                                      : wdata_reg;
            end
            SIO_S_LOCK: begin
                wr_next  = 1'b1;
                iow_next = SIO_KEY_LOCK;
            end
            default: ;
        endcase
    end

    always_comb begin
        hrdata_next = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                SIO_HREG_LDN:    hrdata_next = ldn_reg;
                SIO_HREG_INDEX:  hrdata_next = index_reg;
                SIO_HREG_WDATA:  hrdata_next = wdata_reg;
                SIO_HREG_STATUS: hrdata_next = {7'h00, state_reg != SIO_S_IDLE};
                SIO_HREG_RDATA:  hrdata_next = result_reg;
                default:         hrdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg  <= SIO_S_IDLE;
            op_reg     <= SIO_OP_WRITE;
            ldn_reg    <= 8'h00;
            index_reg  <= 8'h00;
            wdata_reg  <= 8'h00;
            result_reg <= 8'h00;
            hrdata_reg <= 8'h00;
            addr_reg   <= SIO_INDEX_PORT;
            iow_reg    <= 8'h00;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
        end else begin
            state_reg  <= state_next;
            op_reg     <= op_next;
            ldn_reg    <= ldn_next;
            index_reg  <= index_next;
            wdata_reg  <= wdata_next;
            result_reg <= result_next;
            hrdata_reg <= hrdata_next;
            addr_reg   <= addr_next;
            iow_reg    <= iow_next;
            wr_reg     <= wr_next;
            rd_reg     <= rd_next;
        end
    end

    assign bus.io_addr  = addr_reg;
    assign bus.io_wdata = iow_reg;
    assign bus.io_wr    = wr_reg;
    assign bus.io_rd    = rd_reg;
    assign reg_rdata    = hrdata_reg;
endmodule : sio_gpio_host

/* File: sio_asserts.sv */
`timescale 1ns/1ps
module sio_asserts
    import sio_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    input wire logic        config_mode,
    input wire logic [7:0]  gpio_oe,
    input wire logic [7:0]  gpio_out
);
    logic port_hit;
    logic key_wr;
    logic lock_wr;
    logic data_wr;
    logic unlock_now;
    logic key_seen_reg;
    assign port_hit = (io_wr || io_rd) && (io_addr == SIO_INDEX_PORT || io_addr == SIO_DATA_PORT);
    assign key_wr = io_wr && io_addr == SIO_INDEX_PORT && io_wdata == SIO_KEY_UNLOCK;
    assign lock_wr = io_wr && io_addr == SIO_INDEX_PORT && io_wdata == SIO_KEY_LOCK;
    assign data_wr = io_wr && io_addr == SIO_DATA_PORT;
    assign unlock_now = key_wr && key_seen_reg;
    // Whether the last port access was an unlock key write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            key_seen_reg <= 1'b0;
        end else if (port_hit) begin
            key_seen_reg <= key_wr;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    unlock_pair_a: assert property (unlock_now |=> config_mode)
        else $error("config mode not entered after two unlock keys");
    rise_cause_a: assert property ($rose(config_mode) |-> $past(unlock_now))
        else $error("config mode entered without a key pair");
    lock_key_a: assert property (lock_wr |=> !config_mode)
        else $error("config mode kept after lock key");
    stay_locked_a: assert property (!config_mode && !unlock_now |=> !config_mode)
        else $error("config mode left locked state by itself");
    locked_read_a: assert property (io_rd && !(config_mode && port_hit) |=> io_rdata == 8'hff)
        else $error("locked or unmapped read did not return all ones");
    idle_rdata_a: assert property (!io_rd |=> io_rdata == SIO_IDLE_READ)
        else $error("read data outside the answer cycle");
    oe_cause_a: assert property ($changed(gpio_oe) |-> $past(data_wr) || $past(data_wr, 2)
        || !$past(resetn))
        else $error("pin enables changed without a data write");
    out_cause_a: assert property ($changed(gpio_out) |-> $past(data_wr) || $past(data_wr, 2)
        || !$past(resetn))
        else $error("pin drive changed without a data write");
    cover property (unlock_now);
    cover property (io_rd && config_mode);
    cover property (io_rd && !config_mode);
    cover property (gpio_oe == 8'hff);
endmodule : sio_asserts

/* File: superio_gpio_config_port_bench.sv */
`timescale 1ns/1ps
module superio_gpio_config_port_bench
    import sio_pkg::*;
;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] gpio_in = 8'h00;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
    logic       config_mode;
    logic       raw_mode;
    logic [7:0] lfsr = 8'h04;
    int         fail_count = 0;
    int         num_checks = 0;
    int         unlock_seen = 0;
    int         lock_seen = 0;
    sio_io_if bus_if ();
    sio_io_if raw_if ();

    always #2.5 clk = ~clk;

    sio_gpio_dev sio_gpio_dev_i (.clk(clk), .resetn(resetn), .bus(bus_if.dev),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .config_mode(config_mode));
    sio_gpio_host sio_gpio_host_i (.clk(clk), .resetn(resetn), .bus(bus_if.host),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // Second device driven directly, so the bench can break the access rules
    sio_gpio_dev raw_sio_gpio_dev_i (.clk(clk), .resetn(resetn), .bus(raw_if.dev),
        .gpio_in(8'h00), .gpio_out(), .gpio_oe(), .config_mode(raw_mode));
    sio_asserts sio_asserts_i (.clk(clk), .resetn(resetn), .io_addr(bus_if.io_addr),
        .io_wdata(bus_if.io_wdata), .io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd),
        .io_rdata(bus_if.io_rdata), .config_mode(config_mode), .gpio_oe(gpio_oe),
        .gpio_out(gpio_out));

    // Counts key writes seen on the wire between host and device
    always @(posedge clk) begin
        if (bus_if.io_wr === 1'b1 && bus_if.io_addr === SIO_INDEX_PORT) begin
            if (bus_if.io_wdata === SIO_KEY_UNLOCK) unlock_seen++;
            if (bus_if.io_wdata === SIO_KEY_LOCK) lock_seen++;
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    // Data register after a write: input bits keep what they held
    function automatic logic [7:0] merged_value(input logic [7:0] old, input logic [7:0] wr,
                                                input logic [7:0] dir);
        return (old & dir) | (wr & ~dir);
    endfunction : merged_value

    // Readback: input bits show the pin after polarity, output bits the stored value
    function automatic logic [7:0] readback(input logic [7:0] dir, input logic [7:0] pin,
                                           input logic [7:0] pol, input logic [7:0] stored);
        return (dir & (pin ^ pol)) | (~dir & stored);
    endfunction : readback

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic reg_access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                              output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : reg_access

    task automatic host_op(input sio_op_t op, input logic [7:0] ldn, input logic [7:0] idx,
                           input logic [7:0] wd, output logic [7:0] q);
        logic [7:0] s;
        int         u0;
        int         l0;
        int         n;
        u0 = unlock_seen;
        l0 = lock_seen;
        reg_access(1'b1, SIO_HREG_LDN, ldn, s);
        reg_access(1'b1, SIO_HREG_INDEX, idx, s);
        reg_access(1'b1, SIO_HREG_WDATA, wd, s);
        reg_access(1'b1, SIO_HREG_CTRL, {5'h00, op, 1'b1}, s);
        n = 0;
        s = 8'h01;
        while (s[0] !== 1'b0 && n < 40) begin
            reg_access(1'b0, SIO_HREG_STATUS, 8'h00, s);
            n++;
        end
        if (n == 40) fail_count++;
        reg_access(1'b0, SIO_HREG_RDATA, 8'h00, q);
        check("unlock keys", 8'(unlock_seen - u0), 8'h02);
        check("lock keys", 8'(lock_seen - l0), 8'h01);
        check("mode after op", {7'h00, config_mode}, 8'h00);
    endtask : host_op

    // For reads v is the expected answer, for writes the data
    task automatic raw_step(input logic wr, input logic [15:0] a, input logic [7:0] v);
        logic [7:0] q;
        @(posedge clk);
        raw_if.io_addr <= a;
        raw_if.io_wdata <= v;
        raw_if.io_wr <= wr;
        raw_if.io_rd <= !wr;
        @(posedge clk);
        raw_if.io_wr <= 1'b0;
        raw_if.io_rd <= 1'b0;
        raw_if.io_wdata <= ~v;
        #1 q = raw_if.io_rdata;
        if (!wr) check("raw read", q, v);
    endtask : raw_step

    initial begin
        #(20000 * 5);
        fail_count++;
        complete_run();
    end

    initial begin
        logic [7:0] q;
        logic [7:0] dir;
        logic [7:0] pol;
        logic [7:0] val;
        logic [7:0] mval;
        raw_if.io_addr = 16'h0000;
        raw_if.io_wdata = 8'h00;
        raw_if.io_wr = 1'b0;
        raw_if.io_rd = 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        host_op(SIO_OP_READ, SIO_LDN_GPIO, SIO_IDX_DIR, 8'h00, q);
        check("dir reset", q, SIO_RST_DIR);
        host_op(SIO_OP_READ, SIO_LDN_GPIO, SIO_IDX_POLARITY, 8'h00, q);
        check("polarity reset", q, SIO_RST_POLARITY);
        host_op(SIO_OP_WRITE, SIO_LDN_GPIO, SIO_IDX_DIR, 8'h00, q);
        check("oe while disabled", gpio_oe, 8'h00);
        host_op(SIO_OP_WRITE, SIO_LDN_ENABLE, SIO_IDX_DIR, 8'h12, q);
        host_op(SIO_OP_READ, SIO_LDN_GPIO, SIO_IDX_DIR, 8'h00, q);
        check("dir other device", q, 8'h00);
        host_op(SIO_OP_WRITE, SIO_LDN_ENABLE, SIO_IDX_ENABLE, 8'h15, q);
        host_op(SIO_OP_ENABLE, SIO_LDN_ENABLE, SIO_IDX_ENABLE, 8'h00, q);
        host_op(SIO_OP_READ, SIO_LDN_ENABLE, SIO_IDX_ENABLE, 8'h00, q);
        check("enable merge", q, 8'h95);
        check("oe enabled", gpio_oe, 8'hff);
        $display("test reset_enable done");
        mval = SIO_RST_VALUE;
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            dir = (i < 2) ? {8{i[0]}} : lfsr;
            lfsr = lfsr_next(lfsr);
            pol = (i == 0) ? 8'h00 : lfsr;
            lfsr = lfsr_next(lfsr);
            val = lfsr;
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            gpio_in <= lfsr;
            host_op(SIO_OP_WRITE, SIO_LDN_GPIO, SIO_IDX_DIR, dir, q);
            host_op(SIO_OP_WRITE, SIO_LDN_GPIO, SIO_IDX_POLARITY, pol, q);
            host_op(SIO_OP_WRITE, SIO_LDN_GPIO, SIO_IDX_VALUE, val, q);
            mval = merged_value(mval, val, dir);
            check("pin drive", gpio_out, mval ^ pol);
            check("pin enable", gpio_oe, ~dir);
            host_op(SIO_OP_READ, SIO_LDN_GPIO, SIO_IDX_VALUE, 8'h00, q);
            check("pin readback", q, readback(dir, lfsr, pol, mval));
        end
        $display("test pin_loop done");
        raw_step(1'b0, SIO_DATA_PORT, 8'hff);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_KEY_UNLOCK);
        raw_step(1'b1, SIO_DATA_PORT, 8'h55);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_KEY_UNLOCK);
        check("broken unlock", {7'h00, raw_mode}, 8'h00);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_KEY_UNLOCK);
        check("unlocked", {7'h00, raw_mode}, 8'h01);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_IDX_LDN);
        raw_step(1'b1, SIO_DATA_PORT, SIO_LDN_GPIO);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_IDX_DIR);
        raw_step(1'b0, SIO_DATA_PORT, SIO_RST_DIR);
        raw_step(1'b1, SIO_DATA_PORT, 8'h3c);
        raw_step(1'b0, SIO_DATA_PORT, 8'h3c);
        raw_step(1'b0, 16'h002d, 8'hff);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_KEY_LOCK);
        check("locked", {7'h00, raw_mode}, 8'h00);
        raw_step(1'b1, SIO_DATA_PORT, 8'h00);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_KEY_UNLOCK);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_KEY_UNLOCK);
        raw_step(1'b1, SIO_INDEX_PORT, SIO_IDX_DIR);
        raw_step(1'b0, SIO_DATA_PORT, 8'h3c);
        $display("test raw_port done");
        complete_run();
    end
endmodule : superio_gpio_config_port_bench
